// [sppe_pkg.sv]
/*
  Package for the serial peripheral port model: constants, state enum.
  Assumes one system clock (mclk_i) and an active-low asynchronous reset.
*/
// How it works
// - Odd divider not 1, cpol1 phase0: extra pulse
// - Hold, divider 1, idle gap: ready stays low
// - Fixed, hold, dma: bit 24 releases select
// - Master clock pin may toggle before transfer
// - Fixed mode DMA size follows select 0
// - Divider 1, odd length: one extra pulse
// - Divider 1, even length, cpol0 or phase1: clean clock
// - Slave mode ignores the disable command
// - Disable mid-transfer causes endless dummy transfers
// - Software reset keeps enable bit set
// - Idle hold: select switches without switch delay
// - Slow then divider-1 select, cpol1 phase0: extra pulse
// - All selects divider 1, even length: no extra pulse
package sppe_pkg;
  localparam int SPPE_NCS = 4;
  localparam int SPPE_DATA_W = 16;
  localparam int SPPE_WORD_W = 32;
  localparam int SPPE_LAST_BIT = 24;
  localparam int SPPE_PCS_LSB = 16;
  localparam logic [7:0] SPPE_DIV_RST = 8'h01;
  localparam logic [3:0] SPPE_BITS_RST = 4'h8;
  localparam logic [7:0] SPPE_DLY_RST = 8'h00;
  localparam logic [SPPE_NCS-1:0] SPPE_CS_IDLE = 4'hF;
  typedef enum logic [2:0] {
    SPPE_IDLE,
    SPPE_SWITCH,
    SPPE_SHIFT,
    SPPE_GAP,
    SPPE_HOLD
  } sppe_state_t;
endpackage

// [sppe_fifo.sv]
/*
  Small valid/ready FIFO of flip-flops; width and depth are parameters.
  Assumes same clock as the user; depth is a power of two.
*/
`timescale 1ns/1ps
`default_nettype none
module sppe_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic flush_i,
  // Fill side
  input wire logic in_valid_i,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic in_ready_o,
  // Drain side
  output logic out_valid_o,
  output logic [WIDTH-1:0] out_data_o,
  input wire logic out_ready_i
);
  localparam int AW = $clog2(DEPTH);
  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) $error("sppe_fifo: depth must be power of two >= 2");
  end
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } sppe_fifo_st_t;
  sppe_fifo_st_t st_ff, nxt_st;
  logic push, pop;
  ////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    nxt_st = st_ff;
    push = in_valid_i && (st_ff.cnt != (AW+1)'(DEPTH));
    pop = out_ready_i && (st_ff.cnt != '0);
    if (flush_i) begin
      nxt_st.wp = '0;
      nxt_st.rp = '0;
      nxt_st.cnt = '0;
    end else begin
      if (push) begin
        nxt_st.mem[st_ff.wp] = in_data_i;
        nxt_st.wp = st_ff.wp + 1'b1;
      end
      if (pop) begin
        nxt_st.rp = st_ff.rp + 1'b1;
      end
      nxt_st.cnt = st_ff.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
  // Register
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end
  assign in_ready_o = (st_ff.cnt != (AW+1)'(DEPTH));
  assign out_valid_o = (st_ff.cnt != '0);
  assign out_data_o = st_ff.mem[st_ff.rp];
endmodule
`default_nettype wire

// [sppe_port.sv]
/*
  Serial peripheral port master/slave core with its known defects kept.
  Assumes words arrive from software or DMA on the tx word port; config
  bits are plain ports, steady during a transfer; single clock.

  Word layout on the tx port:
    bits 15:0  data, sent most significant bit first
    bits 17:16 inverted select index, used only in variable-select mode
    bit  24    final transfer flag, releases the select after the word

  Defects that are kept on purpose, so users see the real behaviour:
    - an extra clock pair at the end of a word under several divider,
      polarity and length combinations
    - the ready flag stays low after a held idle gap at divider 1
    - a disable command in slave mode is ignored
    - a disable command in mid-transfer starts endless dummy words
    - the software reset leaves the enable state bit set
    - a held select switches to another slave with no switch delay
    - the DMA size in fixed mode follows select 0, not the active one

  Hazards for users:
    - do not change divider, length or polarity while a word shifts
    - only one select line is ever driven low at a time
    - the DMA size output is refreshed on every clock edge
*/
`timescale 1ns/1ps
`default_nettype none
module sppe_port
  import sppe_pkg::*;
#(
  parameter int NCS = SPPE_NCS,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic nrst_i,
  // Commands (one-cycle pulses)
  input wire logic cmd_enable_i,
  input wire logic cmd_disable_i,
  input wire logic cmd_swreset_i,
  // Mode configuration
  input wire logic master_select_bit_i,
  input wire logic fixed_select_i,
  input wire logic dma_feed_i,
  input wire logic [1:0] fixed_cs_i,
  // Per-select configuration, packed by select index; the two delays are shared
  input wire logic [NCS*8-1:0] clock_divider_field_i,
  input wire logic [NCS*4-1:0] word_bits_i,
  input wire logic [NCS-1:0] clock_polarity_bit_i,
  input wire logic [NCS-1:0] clock_phase_bit_i,
  input wire logic [NCS-1:0] hold_select_after_transfer_i,
  input wire logic [7:0] between_transfer_delay_i,
  input wire logic [7:0] select_switch_delay_i,
  // Transmit word stream
  input wire logic tx_valid_i,
  input wire logic [SPPE_WORD_W-1:0] tx_word_i,
  output logic tx_ready_o,
  // Status
  output logic enable_state_bit_o,
  output logic transmit_ready_flag_o,
  output logic transmit_empty_flag_o,
  output logic dma_halfword_o,
  output logic [SPPE_DATA_W-1:0] rx_data_o,
  // Serial pins
  output logic serial_clock_pin_o,
  output logic mosi_o,
  input wire logic miso_i,
  output logic [NCS-1:0] peripheral_select_lines_o
);
  initial begin
    if (NCS != SPPE_NCS) $error("sppe_port: NCS must match the select field width");
  end
  ////////////////////////////////////////////////////////////////////////
  // State
  typedef struct packed {
    sppe_state_t fsm;
    logic en;
    logic txrdy;
    logic txemp;
    logic half;
    logic started;
    logic dummy;
    logic [1:0] cs;
    logic [1:0] prev_cs;
    logic [7:0] divc;
    logic [7:0] dlyc;
    logic [4:0] bitc;
    logic [SPPE_DATA_W-1:0] sh;
    logic [SPPE_DATA_W-1:0] rx;
    logic last;
    logic extra;
    logic sck;
    logic [NCS-1:0] csn;
    logic [2:0] miso_s;
    logic miso_q;
  } sppe_st_t;
  sppe_st_t st_ff, nxt_st;
  // Fifo wires: head valid, pop strobe and flush on software reset
  // The fifo is flushed in the same cycle as the state machine returns
  // to idle, so no word from before the reset is ever shifted out.
  logic f_valid, f_pop, f_flush;
  logic [SPPE_WORD_W-1:0] f_data;
  // Field helpers
  function automatic logic [7:0] div_of(input logic [NCS*8-1:0] v, input logic [1:0] i);
    div_of = v[i*8 +: 8];
  endfunction
  function automatic logic [3:0] bits_of(input logic [NCS*4-1:0] v, input logic [1:0] i);
    bits_of = v[i*4 +: 4];
  endfunction
  // Decoded selects
  logic [1:0] req_cs;
  logic [7:0] cur_div, prev_div;
  logic [4:0] cur_len;
  logic odd_div_glitch;
  always_comb begin
    req_cs = fixed_select_i ? fixed_cs_i : ~f_data[SPPE_PCS_LSB +: 2];
    cur_div = div_of(clock_divider_field_i, st_ff.cs);
    prev_div = div_of(clock_divider_field_i, st_ff.prev_cs);
    cur_len = 5'(bits_of(word_bits_i, st_ff.cs)) + 5'h08;
    // Odd divider other than 1 with polarity 1, phase 0
    odd_div_glitch = cur_div[0] && (cur_div != 8'h01) && clock_polarity_bit_i[st_ff.cs]
                     && !clock_phase_bit_i[st_ff.cs];
  end
  ////////////////////////////////////////////////////////////////////////
  // Word buffer
  sppe_fifo #(.WIDTH(SPPE_WORD_W), .DEPTH(DEPTH)) u_fifo (
    .mclk_i(mclk_i),
    .nrst_i(nrst_i),
    .flush_i(f_flush),
    .in_valid_i(tx_valid_i && st_ff.en),
    .in_data_i(tx_word_i),
    .in_ready_o(tx_ready_o),
    .out_valid_o(f_valid),
    .out_data_o(f_data),
    .out_ready_i(f_pop)
  );
  ////////////////////////////////////////////////////////////////////////
  // Transfer engine
  // One process holds all next-state logic; later assignments win, so
  // the software reset block at the bottom overrides the case below.
  always_comb begin
    nxt_st = st_ff;
    f_pop = 1'b0;
    f_flush = cmd_swreset_i;
    // DMA size decodes select 0 length in fixed mode, every cycle
    nxt_st.half = (fixed_select_i ? bits_of(word_bits_i, 2'd0)
                                  : bits_of(word_bits_i, st_ff.cs)) != '0;
    // Pin sync: change counted once stages 2 and 3 agree
    nxt_st.miso_s = {st_ff.miso_s[1:0], miso_i};
    if (st_ff.miso_s[1] == st_ff.miso_s[2]) begin
      nxt_st.miso_q = st_ff.miso_s[2];
    end
    // Master clock pin may float to polarity before any transfer
    if (master_select_bit_i && !st_ff.started) begin
      nxt_st.sck = clock_polarity_bit_i[0];
    end
    // Commands
    if (cmd_enable_i && !st_ff.en) begin
      nxt_st.en = 1'b1;
      nxt_st.txrdy = 1'b1;
      nxt_st.txemp = 1'b1;
    end
    if (cmd_disable_i) begin
      if (!master_select_bit_i) begin
        nxt_st.en = st_ff.en;
      end else if (st_ff.fsm != SPPE_IDLE && st_ff.fsm != SPPE_HOLD) begin
        nxt_st.dummy = 1'b1;
      end else begin
        nxt_st.en = 1'b0;
        nxt_st.txrdy = 1'b0;
        nxt_st.txemp = 1'b0;
      end
    end
    unique case (st_ff.fsm)
      SPPE_IDLE, SPPE_HOLD: begin
        // Wait for a word or dummy request
        if (st_ff.en && master_select_bit_i && (f_valid || st_ff.dummy)) begin
          nxt_st.prev_cs = st_ff.cs;
          nxt_st.cs = f_valid ? req_cs : st_ff.cs;
          nxt_st.sh = f_valid ? f_data[SPPE_DATA_W-1:0] : '0;
          nxt_st.last = f_valid && f_data[SPPE_LAST_BIT];
          f_pop = f_valid;
          nxt_st.txemp = 1'b0;
          nxt_st.started = 1'b1;
          // Divider 1 with hold and idle gap: ready not raised
          nxt_st.txrdy = !(st_ff.fsm == SPPE_HOLD && cur_div == 8'h01
                           && hold_select_after_transfer_i[st_ff.cs]);
          // Held select switches straight over, skipping switch delay
          nxt_st.fsm = SPPE_SHIFT;
          if (st_ff.fsm == SPPE_IDLE && select_switch_delay_i != SPPE_DLY_RST) begin
            nxt_st.fsm = SPPE_SWITCH;
            nxt_st.dlyc = select_switch_delay_i;
          end
          nxt_st.divc = '0;
          nxt_st.bitc = '0;
          nxt_st.extra = 1'b0;
        end
        if (st_ff.fsm == SPPE_IDLE) begin
          nxt_st.csn = SPPE_CS_IDLE;
        end
      end
      SPPE_SWITCH: begin
        // Select switch delay
        nxt_st.dlyc = st_ff.dlyc - 8'h01;
        if (st_ff.dlyc == 8'h01) begin
          nxt_st.fsm = SPPE_SHIFT;
        end
      end
      SPPE_SHIFT: begin
        nxt_st.csn = ~(NCS'(1) << st_ff.cs);
        nxt_st.divc = st_ff.divc + 8'h01;
        if (st_ff.divc + 8'h01 >= cur_div) begin
          nxt_st.divc = '0;
          nxt_st.sck = !st_ff.sck;
          if (st_ff.sck != clock_polarity_bit_i[st_ff.cs]) begin
            nxt_st.rx = {st_ff.rx[SPPE_DATA_W-2:0], st_ff.miso_q};
            nxt_st.sh = {st_ff.sh[SPPE_DATA_W-2:0], 1'b0};
            nxt_st.bitc = st_ff.bitc + 5'h01;
            if (st_ff.bitc + 5'h01 == cur_len) begin
              // Divider 1 odd length, odd divider glitch, or slow-then-fast
              // select change leaves one extra toggle pair
              nxt_st.extra = !st_ff.extra && (
                (cur_div == 8'h01 && cur_len[0]) || odd_div_glitch ||
                (cur_div == 8'h01 && prev_div != 8'h01 && clock_polarity_bit_i[st_ff.cs]
                 && !clock_phase_bit_i[st_ff.cs]));
              if (!nxt_st.extra) begin
                nxt_st.fsm = SPPE_GAP;
                nxt_st.dlyc = between_transfer_delay_i;
                nxt_st.sck = clock_polarity_bit_i[st_ff.cs];
              end else begin
                nxt_st.bitc = st_ff.bitc;
              end
            end
          end
        end
      end
      SPPE_GAP: begin
        // Between-transfer delay then hold or release
        nxt_st.dlyc = st_ff.dlyc - 8'h01;
        if (st_ff.dlyc == '0 || st_ff.dlyc == 8'h01) begin
          nxt_st.txemp = !f_valid;
          nxt_st.txrdy = 1'b1;
          nxt_st.fsm = (hold_select_after_transfer_i[st_ff.cs] && !st_ff.last)
                       ? SPPE_HOLD : SPPE_IDLE;
          // Fixed DMA hold: bit 24 of the next queued word releases the select
          if (fixed_select_i && dma_feed_i && hold_select_after_transfer_i[st_ff.cs]
              && f_valid && f_data[SPPE_LAST_BIT]) begin
            nxt_st.fsm = SPPE_IDLE;
          end
        end
      end
      default: nxt_st.fsm = SPPE_IDLE;
    endcase
    // Software reset: enable bit kept set
    if (cmd_swreset_i) begin
      nxt_st.fsm = SPPE_IDLE;
      nxt_st.txrdy = 1'b0;
      nxt_st.txemp = 1'b0;
      nxt_st.dummy = 1'b0;
      nxt_st.started = 1'b0;
      nxt_st.csn = SPPE_CS_IDLE;
      nxt_st.en = st_ff.en;
    end
  end
  // Register
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_ff <= '0;
      st_ff.fsm <= SPPE_IDLE;
      st_ff.csn <= SPPE_CS_IDLE;
    end else begin
      st_ff <= nxt_st;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // Outputs straight from state
  assign enable_state_bit_o = st_ff.en;
  assign transmit_ready_flag_o = st_ff.txrdy;
  assign transmit_empty_flag_o = st_ff.txemp;
  assign dma_halfword_o = st_ff.half;
  assign rx_data_o = st_ff.rx;
  assign serial_clock_pin_o = st_ff.sck;
  assign mosi_o = st_ff.sh[SPPE_DATA_W-1];
  assign peripheral_select_lines_o = st_ff.csn;
endmodule
`default_nettype wire

// [sppe_slave_model.sv]
/* Slave on the select lines; counts serial clock edges.
   Assumes mclk_i is the port's clock. */
`timescale 1ns/1ps
`default_nettype none
module sppe_slave_model
  import sppe_pkg::*;
(
  // Clock and pins
  input wire logic mclk_i,
  input wire logic sclk_i,
  input wire logic [SPPE_NCS-1:0] sel_n_i,
  // Reply and count
  output logic miso_o,
  output int edges_o
);
  logic last_ff = 1'b0;
  logic [15:0] reply_ff = 16'hA5C3; // Arbitrary reply
  initial begin
    edges_o = 0;
    miso_o = 1'b0;
  end
  // Count edges while selected; idle line keeps changing
  always @(posedge mclk_i) begin
    last_ff <= sclk_i;
    if (sel_n_i != SPPE_CS_IDLE) begin
      edges_o <= edges_o + int'(sclk_i != last_ff);
      miso_o <= reply_ff[edges_o[3:0]];
    end else begin
      miso_o <= ~miso_o;
    end
  end
endmodule
`default_nettype wire

// [sppe_port_sva.sv]
/* Checker on sppe_port pins and flags.
   Sees only the port's pins; bound below. */
`timescale 1ns/1ps
`default_nettype none
module sppe_port_sva
  import sppe_pkg::*;
#(
  parameter int NCS = SPPE_NCS
) (
  // Clock, reset, commands
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic cmd_enable_i,
  input wire logic cmd_disable_i,
  input wire logic cmd_swreset_i,
  // Mode
  input wire logic master_select_bit_i,
  input wire logic fixed_select_i,
  input wire logic dma_feed_i,
  input wire logic [NCS*4-1:0] word_bits_i,
  // Outputs
  input wire logic enable_state_bit_o,
  input wire logic transmit_ready_flag_o,
  input wire logic transmit_empty_flag_o,
  input wire logic dma_halfword_o,
  input wire logic serial_clock_pin_o,
  input wire logic [NCS-1:0] peripheral_select_lines_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);
  // Reset while enabled, then enable
  sequence s_swr_en;
    enable_state_bit_o && cmd_swreset_i ##1 cmd_enable_i;
  endsequence
  // Fixed DMA mode with steady sizes
  sequence s_size;
    (fixed_select_i && dma_feed_i && $stable(word_bits_i)) [*3];
  endsequence
  property p_rst; $rose(nrst_i) |-> peripheral_select_lines_o == SPPE_CS_IDLE; endproperty
  a_rst: assert property (p_rst)
    else $error("selects active after reset");
  property p_slave; !master_select_bit_i && cmd_disable_i && !cmd_swreset_i
    && enable_state_bit_o |=> enable_state_bit_o; endproperty
  a_slave: assert property (p_slave)
    else $error("slave disable took effect");
  property p_swr; cmd_swreset_i && enable_state_bit_o && !cmd_disable_i
    |=> enable_state_bit_o; endproperty
  a_swr: assert property (p_swr)
    else $error("software reset cleared enable");
  property p_swr_en; s_swr_en |=> !transmit_ready_flag_o && !transmit_empty_flag_o; endproperty
  a_swr_en: assert property (p_swr_en)
    else $error("enable after software reset set flags");
  property p_en; !enable_state_bit_o && cmd_enable_i && !cmd_disable_i && !cmd_swreset_i
    |=> ##[0:1] (enable_state_bit_o && transmit_ready_flag_o && transmit_empty_flag_o);
  endproperty
  a_en: assert property (p_en)
    else $error("enable did not set flags");
  property p_size; s_size |-> dma_halfword_o == (word_bits_i[3:0] != 4'h0); endproperty
  a_size: assert property (p_size)
    else $error("dma size not from select 0");
  property p_busy; $changed(serial_clock_pin_o) && peripheral_select_lines_o != SPPE_CS_IDLE
    |-> !transmit_empty_flag_o; endproperty
  a_busy: assert property (p_busy)
    else $error("clock moved while empty");
  property p_one; $onehot0(~peripheral_select_lines_o); endproperty
  a_one: assert property (p_one)
    else $error("two selects active");
endmodule
bind sppe_port sppe_port_sva #(.NCS(NCS)) i_sva (.mclk_i, .nrst_i, .cmd_enable_i,
  .cmd_disable_i, .cmd_swreset_i, .master_select_bit_i, .fixed_select_i, .dma_feed_i,
  .word_bits_i, .enable_state_bit_o, .transmit_ready_flag_o, .transmit_empty_flag_o,
  .dma_halfword_o, .serial_clock_pin_o, .peripheral_select_lines_o);
`default_nettype wire

// [serial_peripheral_port_errata_test.sv]
/* Bench: clock pulses per word against a model, flags, sizes.
   Assumes the slave model and checker are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module serial_peripheral_port_errata_test;
  import sppe_pkg::*;
  logic mclk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic [2:0] cmd = 3'h0; // Enable, disable, reset
  logic master_select_bit = 1'b0, fixd = 1'b1, dma = 1'b0, tv = 1'b0;
  logic [1:0] fcs = 2'h0;
  logic [31:0] div = 32'h01010101, tw = 32'h0;
  logic [15:0] bits = 16'h0;
  logic [3:0] clock_polarity_bit = 4'h0, cpha = 4'h0, sel;
  logic trdy, enb, rdy, emp, half, sck, mosi, miso;
  int edges, mismatches = 0, num_checks = 0, seed = 32'hf8ca, e0, k, pd = 1, pcs = 0;
  int exp_q[$];
  always #2 mclk_i = ~mclk_i;
  sppe_port i_dut (.mclk_i(mclk_i), .nrst_i(nrst_i), .cmd_enable_i(cmd[2]),
    .cmd_disable_i(cmd[1]), .cmd_swreset_i(cmd[0]), .master_select_bit_i(master_select_bit),
    .fixed_select_i(fixd), .dma_feed_i(dma), .fixed_cs_i(fcs), .clock_divider_field_i(div),
    .word_bits_i(bits), .clock_polarity_bit_i(clock_polarity_bit), .clock_phase_bit_i(cpha),
    .hold_select_after_transfer_i(4'h0), .between_transfer_delay_i(8'h00),
    .select_switch_delay_i(8'h00), .tx_valid_i(tv), .tx_word_i(tw), .tx_ready_o(trdy),
    .enable_state_bit_o(enb), .transmit_ready_flag_o(rdy), .transmit_empty_flag_o(emp),
    .dma_halfword_o(half), .rx_data_o(), .serial_clock_pin_o(sck), .mosi_o(mosi),
    .miso_i(miso), .peripheral_select_lines_o(sel));
  sppe_slave_model i_slave (.mclk_i(mclk_i), .sclk_i(sck), .sel_n_i(sel), .miso_o(miso),
    .edges_o(edges));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    if (mismatches == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic pulse(input logic [2:0] v);
    @(posedge mclk_i) cmd <= v;
    @(posedge mclk_i) cmd <= 3'h0;
    repeat (2) @(posedge mclk_i);
  endtask
  // Bounded wait for the empty flag
  task automatic wait_empty(input int lim);
    int n;
    n = 0;
    while (emp !== 1'b1 && n < lim) begin
      @(posedge mclk_i);
      n++;
    end
    if (n >= lim) begin
      mismatches++;
      stop_test();
    end
  endtask
  // One word held until taken
  task automatic send(input logic [31:0] w);
    int n;
    n = 0;
    @(posedge mclk_i) tv <= 1'b1;
    tw <= w;
    do begin
      @(posedge mclk_i);
      n++;
    end while (trdy !== 1'b1 && n < 50);
    tv <= 1'b0;
    if (n >= 50) begin
      mismatches++;
      stop_test();
    end
  endtask
  // Configure a select, send a word, compare pulse count
  task automatic run(input int cs, input int d, input int len, input logic cp, input logic ph);
    @(posedge mclk_i) div[cs*8+:8] <= d[7:0];
    bits[cs*4+:4] <= 4'(len - 8);
    clock_polarity_bit[cs] <= cp;
    cpha[cs] <= ph;
    fcs <= cs[1:0];
    exp_q.push_back(len + int'((d == 1 && len % 2 == 1) || (d != 1 && d % 2 == 1 && cp && !ph)
      || (d == 1 && cp && !ph && pd != 1 && pcs != cs)));
    pd = d;
    pcs = cs;
    e0 = edges;
    send({7'h00, 1'b1, 6'h00, ~cs[1:0], 16'($random(seed))});
    repeat (3) @(posedge mclk_i);
    wait_empty(2000);
    check((edges - e0 + 1) / 2, exp_q.pop_front());
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge mclk_i);
    nrst_i <= 1'b1;
    @(posedge mclk_i) master_select_bit <= 1'b1;
    pulse(3'b100);
    for (int n = 8; n <= 16; n++) run(0, 1, n, 1'b0, 1'b0);
    run(1, 3, 8, 1'b1, 1'b0);
    run(0, 1, 8, 1'b1, 1'b0);
    run(1, 1, 8, 1'b1, 1'b0);
    run(2, 2, 10, 1'b1, 1'b0);
    run(3, 8, 16, 1'b0, 1'b1);
    // Fill the queue until refused, then drain
    e0 = edges;
    k = 0;
    @(posedge mclk_i) tv <= 1'b1;
    repeat (8) begin
      @(posedge mclk_i);
      if (trdy === 1'b1) begin
        k++;
        tw <= {16'h0100, 16'($random(seed))};
      end
    end
    tv <= 1'b0;
    check(trdy, 0);
    check(k >= 4 && k <= 5, 1);
    repeat (3) @(posedge mclk_i);
    wait_empty(3000);
    check((edges - e0 + 1) / 2, 16 * k);
    check(trdy, 1);
    // Size toward the DMA channel
    @(posedge mclk_i) dma <= 1'b1; // select not held under DMA
    bits[7:0] <= 8'h02;
    fcs <= 2'h1;
    repeat (3) @(posedge mclk_i);
    check(half, 1);
    @(posedge mclk_i) bits[3:0] <= 4'h0;
    repeat (3) @(posedge mclk_i);
    check(half, 0);
    // Slave disable, software reset, re-enable
    @(posedge mclk_i) master_select_bit <= 1'b0;
    pulse(3'b010);
    check(enb, 1);
    @(posedge mclk_i) cmd <= 3'b001;
    @(posedge mclk_i) cmd <= 3'b100;
    pulse(3'b000);
    check({enb, rdy, emp}, 3'b100);
    @(posedge mclk_i) master_select_bit <= 1'b1;
    pulse(3'b010);
    check(enb, 0);
    pulse(3'b100);
    check({enb, rdy, emp}, 3'b111);
    // Disable in mid-transfer
    @(posedge mclk_i) dma <= 1'b0;
    fcs <= 2'h3;
    send({16'h0000, 16'($random(seed))});
    repeat (20) @(posedge mclk_i);
    pulse(3'b010);
    e0 = edges;
    repeat (600) @(posedge mclk_i);
    check(emp, 0);
    check(edges != e0, 1);
    stop_test();
  end
endmodule
`default_nettype wire
